// file: hdl/anpr_pkg.sv
// Constants for the next-page register bank
// Function
// [R1] Next-page transmit word: NP, zero, MP, ACK2, toggle, 11-bit code
// [R2] Written NP, MP, ACK2 and code go out in the next page sent
// [R3] Bit 14 of every sent page is zero; writes to it are dropped
// [R4] Device makes toggle as inverse of previous page's toggle
// [R5] Management loads each page; device drives it as the config word
// [R6] Read-only partner next-page word with the same field layout
// [R7] Each received next page is stored unchanged in the partner word
// [R8] Software trusts the partner word only after complete or page flag
// [R9] Complete status bit set on entry to link-up
// [R10] Complete bit stays zero if idles never lead to link-up
// [R11] Next-page request follows the advertisement next-page bit
// [R12] From complete-acknowledge, a run of idles enters link-up
// [R13] Page flag set on each new page, cleared by reading expansion
package anpr_pkg;
  localparam logic [4:0]  ANPR_ADDR_STATUS = 5'h01;
  localparam logic [4:0]  ANPR_ADDR_ADV    = 5'h04;
  localparam logic [4:0]  ANPR_ADDR_EXP    = 5'h06;
  localparam logic [4:0]  ANPR_ADDR_NPTX   = 5'h07;
  localparam logic [4:0]  ANPR_ADDR_LPNP   = 5'h08;
  localparam int          ANPR_NP_BIT      = 15;
  localparam int          ANPR_RSVD_BIT    = 14;
  localparam int          ANPR_MP_BIT      = 13;
  localparam int          ANPR_ACK2_BIT    = 12;
  localparam int          ANPR_TGL_BIT     = 11;
  localparam int          ANPR_CODE_MSB    = 10;
  localparam int          ANPR_DONE_BIT    = 5;
  localparam int          ANPR_PAGE_BIT    = 1;
  localparam logic [15:0] ANPR_NPTX_RST    = 16'h0000;
  localparam logic [15:0] ANPR_LPNP_RST    = 16'h0000;
  localparam logic [3:0]  ANPR_IDLE_RUN    = 4'h3;
endpackage : anpr_pkg

// file: hdl/anpr_link_mon.sv
// Link-up tracker: run of idle sets after complete-acknowledge
`timescale 1ns/100ps
module anpr_link_mon (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Arbitration and receive events
  input  wire logic an_restart,
  input  wire logic arb_complete_ack,
  input  wire logic rx_idle,
  input  wire logic rx_config_valid,
  // Link state
  output logic      link_ok,
  output logic      link_ok_entry
);
  import anpr_pkg::*;

  logic [3:0] idle_cnt;
  logic [3:0] next_idle_cnt;
  logic       next_link_ok;
  wire        run_done = rx_idle && (idle_cnt == ANPR_IDLE_RUN - 4'h1);

  // [R12] Idle run to link
  assign next_link_ok  = an_restart ? 1'b0 :
                         (link_ok || (arb_complete_ack && run_done));
  assign link_ok_entry = next_link_ok && !link_ok;
  assign next_idle_cnt = (an_restart || !arb_complete_ack || rx_config_valid)
                         ? 4'h0
                         : (rx_idle && !run_done) ? idle_cnt + 4'h1 : idle_cnt;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      link_ok  <= 1'b0;
      idle_cnt <= 4'h0;
    end else begin
      link_ok  <= next_link_ok;
      idle_cnt <= next_idle_cnt;
    end
  end

  AST_LINK_AFTER_IDLE: assert property ( // [R12]
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(link_ok) |-> $past(rx_idle) && $past(arb_complete_ack))
    else $error("Link-up without idle in complete-acknowledge");

  AST_NO_LINK_WITHOUT_RUN: assert property ( // [R10]
    @(posedge clk_sys) disable iff (!arst_n)
    (!link_ok && !rx_idle) |=> !link_ok)
    else $error("Link-up reached without an idle set");

  COV_LINK_UP: cover property (
    @(posedge clk_sys) disable iff (!arst_n) $rose(link_ok));
endmodule : anpr_link_mon

// file: hdl/anpr_top.sv
// Next-page transmit, partner next-page and completion status registers
`timescale 1ns/100ps
module anpr_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Management register port
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  input  wire logic [15:0] mgmt_wdata,
  output logic [15:0]      mgmt_rdata,
  output logic             mgmt_rvalid,
  // Arbitration side
  input  wire logic        an_restart,
  input  wire logic        arb_complete_ack,
  input  wire logic        np_take,
  output logic [15:0]      tx_page,
  output logic             np_loaded,
  output logic             np_request,
  output logic             link_ok,
  // Receive side
  input  wire logic        rx_page_valid,
  input  wire logic        rx_page_next,
  input  wire logic [15:0] rx_page,
  input  wire logic        rx_idle,
  input  wire logic        rx_config_valid
);
  import anpr_pkg::*;

  logic [15:0] next_page_transmit;
  logic [15:0] partner_next_page_ability;
  logic        last_toggle;
  logic        adv_np;
  logic        page_received_flag;
  logic        an_complete;
  logic        link_ok_entry;
  logic        tgl_hist_vld;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction : hit

  wire wr_nptx  = mgmt_wr && hit(mgmt_addr, ANPR_ADDR_NPTX);
  wire wr_adv   = mgmt_wr && hit(mgmt_addr, ANPR_ADDR_ADV);
  wire rd_exp   = mgmt_rd && hit(mgmt_addr, ANPR_ADDR_EXP);
  wire rx_np    = rx_page_valid && rx_page_next;

  // [R1] Transmit word view
  wire [15:0] nptx_view = {next_page_transmit[ANPR_NP_BIT], 1'b0,
                           next_page_transmit[ANPR_MP_BIT],
                           next_page_transmit[ANPR_ACK2_BIT], !last_toggle,
                           next_page_transmit[ANPR_CODE_MSB:0]};

  // [R3] Reserved bit dropped
  wire [15:0] nptx_wmask = 16'hbfff & ~(16'h0001 << ANPR_TGL_BIT);

  wire [15:0] next_nptx = wr_nptx ? (mgmt_wdata & nptx_wmask)
                                  : next_page_transmit;

  wire [15:0] status_view = 16'h0000 | ({15'h0000, an_complete}
                                        << ANPR_DONE_BIT);
  wire [15:0] exp_view    = 16'h0000 | ({15'h0000, page_received_flag}
                                        << ANPR_PAGE_BIT);
  wire [15:0] adv_view    = {adv_np, 15'h0000};

  // [R6] Read mux, partner word read-only
  wire [15:0] next_rdata =
    hit(mgmt_addr, ANPR_ADDR_STATUS) ? status_view :
    hit(mgmt_addr, ANPR_ADDR_ADV)    ? adv_view :
    hit(mgmt_addr, ANPR_ADDR_EXP)    ? exp_view :
    hit(mgmt_addr, ANPR_ADDR_NPTX)   ? nptx_view :
    hit(mgmt_addr, ANPR_ADDR_LPNP)   ? partner_next_page_ability :
                                       16'h0000;

  anpr_link_mon u_link_mon (
    .clk_sys          (clk_sys),
    .arst_n           (arst_n),
    .an_restart       (an_restart),
    .arb_complete_ack (arb_complete_ack),
    .rx_idle          (rx_idle),
    .rx_config_valid  (rx_config_valid),
    .link_ok          (link_ok),
    .link_ok_entry    (link_ok_entry)
  );

  // [R11] Next-page request
  assign np_request = adv_np;

  // Register writes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      next_page_transmit <= ANPR_NPTX_RST;
      adv_np             <= 1'b0;
    end else begin
      next_page_transmit <= next_nptx;
      if (wr_adv) begin
        adv_np <= mgmt_wdata[ANPR_NP_BIT];
      end
    end
  end

  // [R2] [R4] [R5] Page sent to link
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_page     <= 16'h0000;
      last_toggle <= 1'b0;
    end else if (an_restart) begin
      last_toggle <= 1'b0;
    end else if (np_take) begin
      tx_page     <= nptx_view;
      last_toggle <= !last_toggle;
    end
  end

  // [R5] Loaded flag, write wins over take
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      np_loaded <= 1'b0;
    end else if (wr_nptx) begin
      np_loaded <= 1'b1;
    end else if (np_take || an_restart) begin
      np_loaded <= 1'b0;
    end
  end

  // [R7] Partner page capture
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      partner_next_page_ability <= ANPR_LPNP_RST;
    end else if (rx_np) begin
      partner_next_page_ability <= rx_page;
    end
  end

  // [R13] Page flag, arrival wins over read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      page_received_flag <= 1'b0;
    end else if (rx_page_valid) begin
      page_received_flag <= 1'b1;
    end else if (rd_exp) begin
      page_received_flag <= 1'b0;
    end
  end

  // [R9] [R10] Completion on link-up entry
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      an_complete <= 1'b0;
    end else if (link_ok_entry) begin
      an_complete <= 1'b1;
    end else if (an_restart) begin
      an_complete <= 1'b0;
    end
  end

  // Read data
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mgmt_rdata  <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rdata  <= mgmt_rd ? next_rdata : mgmt_rdata;
      mgmt_rvalid <= mgmt_rd;
    end
  end

  // Page sent since restart, for the toggle check
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tgl_hist_vld <= 1'b0;
    end else if (an_restart) begin
      tgl_hist_vld <= 1'b0;
    end else if (np_take) begin
      tgl_hist_vld <= 1'b1;
    end
  end

  AST_NPTX_FIELDS: assert property ( // [R2]
    @(posedge clk_sys) disable iff (!arst_n)
    (wr_nptx && !an_restart) ##1 (np_take && !wr_nptx && !an_restart)
    |=> (tx_page[15] == $past(mgmt_wdata[15], 2))
        && (tx_page[13:12] == $past(mgmt_wdata[13:12], 2))
        && (tx_page[10:0] == $past(mgmt_wdata[10:0], 2)))
    else $error("Sent page does not carry written fields");

  AST_RSVD_ZERO: assert property ( // [R3]
    @(posedge clk_sys) disable iff (!arst_n)
    np_take && !an_restart |=> !tx_page[ANPR_RSVD_BIT])
    else $error("Reserved bit sent as one");

  AST_TOGGLE_FLIPS: assert property ( // [R4]
    @(posedge clk_sys) disable iff (!arst_n)
    np_take && !an_restart
    |=> tx_page[ANPR_TGL_BIT] == ($past(tgl_hist_vld)
                                   ? !$past(tx_page[ANPR_TGL_BIT])
                                   : 1'b1))
    else $error("Toggle not inverted from previous page");

  AST_LOADED_SET: assert property ( // [R5]
    @(posedge clk_sys) disable iff (!arst_n)
    wr_nptx |=> np_loaded)
    else $error("Write did not mark page loaded");

  AST_LPNP_CAPTURE: assert property ( // [R7]
    @(posedge clk_sys) disable iff (!arst_n)
    rx_np |=> partner_next_page_ability == $past(rx_page))
    else $error("Partner page not stored unchanged");

  AST_DONE_ON_LINK: assert property ( // [R9]
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(link_ok) |-> an_complete)
    else $error("Complete bit not set on link-up");

  AST_DONE_NEEDS_LINK: assert property ( // [R10]
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(an_complete) |-> $rose(link_ok))
    else $error("Complete bit set without link-up");

  AST_NP_REQUEST: assert property ( // [R11]
    @(posedge clk_sys) disable iff (!arst_n)
    wr_adv |=> np_request == $past(mgmt_wdata[ANPR_NP_BIT]))
    else $error("Request does not follow advertisement bit");

  AST_PAGE_FLAG: assert property ( // [R13]
    @(posedge clk_sys) disable iff (!arst_n)
    rx_page_valid |=> page_received_flag)
    else $error("Page flag not set on arrival");

  AST_FLAG_CLEAR: assert property ( // [R13]
    @(posedge clk_sys) disable iff (!arst_n)
    rd_exp && !rx_page_valid |=> !page_received_flag)
    else $error("Page flag not cleared by read");

  COV_NP_SENT: cover property (
    @(posedge clk_sys) disable iff (!arst_n) wr_nptx ##[1:20] np_take);
  COV_NP_RECEIVED: cover property (
    @(posedge clk_sys) disable iff (!arst_n) rx_np ##[1:20] rd_exp);
  COV_SET_CLEAR_CLASH: cover property (
    @(posedge clk_sys) disable iff (!arst_n) rx_page_valid && rd_exp);
endmodule : anpr_top

// file: tb/anpr_peer_model.sv
// Remote link partner model: sends pages, idle sets and config sets
`timescale 1ns/100ps
module anpr_peer_model (
  // Clock
  input  wire logic   clk_sys,
  // Receive-side events
  output logic        rx_page_valid,
  output logic        rx_page_next,
  output logic [15:0] rx_page,
  output logic        rx_idle,
  output logic        rx_config_valid
);
  initial begin
    rx_page_valid   = 1'b0;
    rx_page_next    = 1'b0;
    rx_idle         = 1'b0;
    rx_config_valid = 1'b0;
    rx_page = 16'h5a5a;
  end
  // Page word for one set, then inverted
  task automatic send_page(input logic nxt, input logic [15:0] w);
    @(posedge clk_sys) #2;
    rx_page_valid = 1'b1;
    rx_page_next  = nxt;
    rx_page       = w;
    @(posedge clk_sys) #2;
    rx_page_valid = 1'b0;
    rx_page       = ~w;
  endtask : send_page
  // One idle set, or one config set
  task automatic send_set(input logic idle);
    @(posedge clk_sys) #2;
    rx_idle         = idle;
    rx_config_valid = !idle;
    @(posedge clk_sys) #2;
    rx_idle         = 1'b0;
    rx_config_valid = 1'b0;
  endtask : send_set
endmodule : anpr_peer_model

// file: tb/anpr_top_tb_top.sv
// Self-checking bench for the next-page register bank
`timescale 1ns/100ps
module anpr_top_tb_top;
  import anpr_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic [4:0]  mgmt_addr = 5'h00;
  logic        mgmt_wr = 1'b0;
  logic        mgmt_rd = 1'b0;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic [15:0] mgmt_rdata;
  logic        mgmt_rvalid;
  logic        an_restart = 1'b0;
  logic        arb_complete_ack = 1'b0;
  logic        np_take = 1'b0;
  logic [15:0] tx_page, rx_page;
  logic        np_loaded, np_request, link_ok;
  logic        rx_page_valid, rx_page_next, rx_idle, rx_config_valid;
  int          n_errors = 0;
  int          checks = 0;
  // Write data beside the expected sent page and read-back
  logic [15:0] rows [4][2] = '{'{16'h2001, 16'h2801},
    '{16'hffff, 16'hb7ff}, '{16'h7402, 16'h3c02}, '{16'h0000, 16'h0000}};
  always #12.5 clk_sys = ~clk_sys;
  anpr_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .mgmt_addr(mgmt_addr),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .an_restart(an_restart), .arb_complete_ack(arb_complete_ack),
    .np_take(np_take), .tx_page(tx_page), .np_loaded(np_loaded),
    .np_request(np_request), .link_ok(link_ok),
    .rx_page_valid(rx_page_valid), .rx_page_next(rx_page_next),
    .rx_page(rx_page), .rx_idle(rx_idle),
    .rx_config_valid(rx_config_valid));
  anpr_peer_model peer (.clk_sys(clk_sys), .rx_page_valid(rx_page_valid),
    .rx_page_next(rx_page_next), .rx_page(rx_page), .rx_idle(rx_idle),
    .rx_config_valid(rx_config_valid));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys) #2;
    mgmt_addr  = a;
    mgmt_wdata = d;
    mgmt_wr    = 1'b1;
    @(posedge clk_sys) #2;
    mgmt_wr = 1'b0;
  endtask : wr
  task automatic rchk(input logic [4:0] a, input logic [15:0] m,
                      input logic [15:0] exp);
    @(posedge clk_sys) #2;
    mgmt_addr = a;
    mgmt_rd   = 1'b1;
    @(posedge clk_sys) #2;
    mgmt_rd = 1'b0;
    chk({15'h0000, mgmt_rvalid}, 16'h0001);
    chk(mgmt_rdata & m, exp);
  endtask : rchk
  task automatic pulse(input logic tk);
    @(posedge clk_sys) #2;
    np_take    = tk;
    an_restart = !tk;
    @(posedge clk_sys) #2;
    np_take    = 1'b0;
    an_restart = 1'b0;
  endtask : pulse
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  initial begin
    #(4000 * 25);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    #2 arst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(ANPR_ADDR_NPTX, rows[i][0]);
      chk({15'h0000, np_loaded}, 16'h0001);
      rchk(ANPR_ADDR_NPTX, 16'hffff, rows[i][1]);
      pulse(1'b1);
      chk(tx_page, rows[i][1]);
      chk({15'h0000, np_loaded}, 16'h0000);
    end
    wr(ANPR_ADDR_LPNP, 16'hffff);
    rchk(ANPR_ADDR_LPNP, 16'hffff, 16'h0000);
    rchk(ANPR_ADDR_STATUS, 16'hffff, 16'h0000);
    rchk(ANPR_ADDR_EXP, 16'h0002, 16'h0000);
    rchk(5'h1f, 16'hffff, 16'h0000);
    wr(ANPR_ADDR_ADV, 16'hffff);
    chk({15'h0000, np_request}, 16'h0001);
    rchk(ANPR_ADDR_ADV, 16'hffff, 16'h8000);
    wr(ANPR_ADDR_ADV, 16'h0000);
    chk({15'h0000, np_request}, 16'h0000);
    peer.send_page(1'b1, 16'h7401);
    rchk(ANPR_ADDR_EXP, 16'h0002, 16'h0002);
    rchk(ANPR_ADDR_EXP, 16'h0002, 16'h0000);
    rchk(ANPR_ADDR_LPNP, 16'hffff, 16'h7401);
    peer.send_page(1'b0, 16'h4020);
    rchk(ANPR_ADDR_LPNP, 16'hffff, 16'h7401);
    rchk(ANPR_ADDR_EXP, 16'h0002, 16'h0002);
    pulse(1'b0);
    // Take on the edge right after the write
    @(posedge clk_sys) #2;
    mgmt_addr  = ANPR_ADDR_NPTX;
    mgmt_wdata = 16'h1234;
    mgmt_wr    = 1'b1;
    @(posedge clk_sys) #2;
    mgmt_wr = 1'b0;
    np_take = 1'b1;
    @(posedge clk_sys) #2;
    np_take = 1'b0;
    chk(tx_page, 16'h1a34);
    chk({15'h0000, np_loaded}, 16'h0000);
    arb_complete_ack = 1'b1;
    peer.send_set(1'b1);
    peer.send_set(1'b1);
    peer.send_set(1'b0);
    peer.send_set(1'b1);
    peer.send_set(1'b1);
    chk({15'h0000, link_ok}, 16'h0000);
    rchk(ANPR_ADDR_STATUS, 16'h0020, 16'h0000);
    peer.send_set(1'b1);
    chk({15'h0000, link_ok}, 16'h0001);
    rchk(ANPR_ADDR_STATUS, 16'h0020, 16'h0020);
    arb_complete_ack = 1'b0;
    pulse(1'b0);
    chk({15'h0000, link_ok}, 16'h0000);
    rchk(ANPR_ADDR_STATUS, 16'h0020, 16'h0000);
    // Mid-run reset clears outputs and toggle history
    wr(ANPR_ADDR_ADV, 16'h8000);
    wr(ANPR_ADDR_NPTX, 16'h0001);
    @(posedge clk_sys) #2;
    arst_n = 1'b0;
    #1;
    chk(tx_page, 16'h0000);
    chk({np_request, np_loaded, link_ok, 13'h0000}, 16'h0000);
    repeat (2) @(posedge clk_sys);
    #2 arst_n = 1'b1;
    rchk(ANPR_ADDR_NPTX, 16'hffff, 16'h0800);
    stop_test();
  end
endmodule : anpr_top_tb_top
